// File: design/pmc_pkg.sv
// Package with register map, field positions, reset values and serial framing constants.
`default_nettype none
package pmc_pkg;
    localparam int unsigned REG_W = 5;
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned REG_COUNT = 5;
    localparam logic [2:0] ADDR_MODE = 3'h0;
    localparam logic [2:0] ADDR_PLL2 = 3'h1;
    localparam logic [2:0] ADDR_OUT1 = 3'h2;
    localparam logic [2:0] ADDR_OUT2 = 3'h3;
    localparam logic [2:0] ADDR_OEN = 3'h4;
    localparam logic [4:0] RST_MODE = 5'h00;
    localparam logic [4:0] RST_PLL2 = 5'h00;
    localparam logic [4:0] RST_OUT1 = 5'h00;
    localparam logic [4:0] RST_OUT2 = 5'h00;
    localparam logic [4:0] RST_OEN = 5'h00;
    localparam int unsigned BIT_PLL_EN = 0;
    localparam int unsigned BIT_FRAME_EN = 4;
    localparam int unsigned BIT_DRV1_EN = 3;
    localparam int unsigned BIT_DRV2_EN = 2;
    localparam int unsigned BIT_LDET2_DIS = 1;
    localparam int unsigned BIT_LDET1_DIS = 0;
    localparam logic [3:0] MODE_HS_REVERSE = 4'hD;
    localparam logic [2:0] HEAD_LAST = 3'h3;
    localparam logic [2:0] DATA_LAST = 3'h4;
    localparam logic [3:0] MULT_X1 = 4'h1;
    localparam logic [3:0] MULT_X2 = 4'h2;
    localparam logic [3:0] MULT_X4 = 4'h4;
    localparam logic [3:0] MULT_X8 = 4'h8;
    typedef enum logic [4:0] {
        SER_IDLE = 5'h01,
        SER_HEAD = 5'h02,
        SER_WDATA = 5'h04,
        SER_RDATA = 5'h08,
        SER_DONE = 5'h10
    } pmc_ser_t;
endpackage
`default_nettype wire

// File: design/pmc_regs.sv
// Command register bank with serial access and mode and multiplier decoding.
// Behaviour
// - High-speed reverse decoding ignores the master or slave strap entirely.
// - High-speed reverse mode reports 64kHz reference and M of 1, 2, 4 or 8.
// - Mode code 1101 in mode register bits 4..1 selects high-speed reverse mode.
// - First output M decodes from register 2: 0000X=1, 0001X=2, 001XX=4, else 8.
// - Second output M decodes from register 3 with the same pattern.
// - First clock runs only while mode register bit 0 is one.
// - Second clock runs only while second PLL control bit 0 is one.
// - Output enable register: frame pulse, driver 1, driver 2, lock-detect disables.
// - Forward/slave mode uses 8kHz reference and multiple L from 1 to 32.
// - Register 2 holds L minus one for the first output; zero gives L of 1.
// - Register 3 holds L minus one for the second output.
`default_nettype none
module pmc_regs
    import pmc_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Serial control port.
    input wire logic i_sclk,
    input wire logic i_sdi,
    input wire logic i_cs_n,
    output logic o_sdo,
    output logic o_sdo_oe,
    // Master or slave strap, high for master.
    input wire logic i_primary_sel,
    // Decoded mode.
    output logic o_hs_reverse,
    output logic o_fwd_slave,
    output logic o_slave,
    output logic [3:0] o_mode_code,
    output logic o_ref_64k,
    output logic o_ref_8k,
    // Output multipliers.
    output logic [3:0] o_out1_hs_mult,
    output logic [3:0] o_out2_hs_mult,
    output logic [5:0] o_out1_multiple,
    output logic [5:0] o_out2_multiple,
    // Clock and driver enables.
    output logic o_first_clock_run,
    output logic o_second_clock_run,
    output logic o_first_clock_drive,
    output logic o_second_clock_drive,
    output logic o_frame_pulse_enable,
    output logic o_pll1_lock_detect_enable,
    output logic o_pll2_lock_detect_enable
);

    // Maps a select register onto the power-of-two multiplier.
    function automatic logic [3:0] hs_mult(input logic [4:0] sel);
        logic [3:0] m;
        m = MULT_X1;
        if (sel[4] || sel[3]) begin
            m = MULT_X8;
        end else if (sel[2]) begin
            m = MULT_X4;
        end else if (sel[1]) begin
            m = MULT_X2;
        end
        return m;
    endfunction

    logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
    logic cs_s1_q, cs_s2_q;
    logic sdi_s1_q, sdi_s2_q;
    logic sclk_rise, sclk_fall, cs_active;
    pmc_ser_t ser_q;
    logic [2:0] cnt_q;
    logic [3:0] head_q;
    logic [4:0] wdata_q;
    logic [4:0] rdata_q;
    logic wr_q;
    logic [REG_W-1:0] regs_q [REG_COUNT];
    logic strap_s1_q, strap_s2_q;
    logic [4:0] mode_reg, pll2_reg, out1_reg, out2_reg, oen_reg;

    // Pins pass two flip-flops; the second stage feeds logic, and the serial clock adds a third stage for edge detection.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            sdi_s1_q <= 1'b0;
            sdi_s2_q <= 1'b0;
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
        end else begin
            sclk_s1_q <= i_sclk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            cs_s1_q <= i_cs_n;
            cs_s2_q <= cs_s1_q;
            sdi_s1_q <= i_sdi;
            sdi_s2_q <= sdi_s1_q;
            strap_s1_q <= i_primary_sel;
            strap_s2_q <= strap_s1_q;
        end
    end

    assign sclk_rise = sclk_s2_q && !sclk_s3_q;
    assign sclk_fall = !sclk_s2_q && sclk_s3_q;
    assign cs_active = !cs_s2_q;

    // Frame sequencer: read flag and address, then five data bits, MSB first.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ser_q <= SER_IDLE;
            cnt_q <= 3'h0;
            head_q <= 4'h0;
            wdata_q <= 5'h00;
            wr_q <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            if (!cs_active) begin
                ser_q <= SER_IDLE;
                cnt_q <= 3'h0;
            end else begin
                case (ser_q)
                    SER_IDLE: begin
                        ser_q <= SER_HEAD;
                        cnt_q <= 3'h0;
                    end
                    SER_HEAD: begin
                        if (sclk_rise) begin
                            head_q <= {head_q[2:0], sdi_s2_q};
                            cnt_q <= cnt_q + 3'h1;
                            if (cnt_q == HEAD_LAST) begin
                                ser_q <= head_q[2] ? SER_RDATA : SER_WDATA;
                                cnt_q <= 3'h0;
                            end
                        end
                    end
                    SER_WDATA: begin
                        if (sclk_rise) begin
                            wdata_q <= {wdata_q[3:0], sdi_s2_q};
                            cnt_q <= cnt_q + 3'h1;
                            if (cnt_q == DATA_LAST) begin
                                wr_q <= 1'b1;
                                ser_q <= SER_DONE;
                            end
                        end
                    end
                    SER_RDATA: begin
                        if (sclk_fall) begin
                            cnt_q <= cnt_q + 3'h1;
                            if (cnt_q == DATA_LAST) begin
                                ser_q <= SER_DONE;
                            end
                        end
                    end
                    SER_DONE: begin
                        ser_q <= SER_DONE;
                    end
                    default: begin
                        ser_q <= SER_IDLE;
                    end
                endcase
            end
        end
    end

    // Read shifter and serial output driver.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q <= 5'h00;
            o_sdo <= 1'b0;
            o_sdo_oe <= 1'b0;
        end else begin
            if (ser_q == SER_HEAD && sclk_rise && cnt_q == HEAD_LAST) begin
                rdata_q <= (head_q[1:0] <= ADDR_OEN[1:0] || {head_q[1:0], sdi_s2_q} <= ADDR_OEN)
                    && {head_q[1:0], sdi_s2_q} < 3'(REG_COUNT) ? regs_q[{head_q[1:0], sdi_s2_q}] : 5'h00;
            end else if (ser_q == SER_RDATA && sclk_fall) begin
                rdata_q <= {rdata_q[3:0], 1'b0};
            end
            if (!cs_active) begin
                o_sdo_oe <= 1'b0;
            end else if (ser_q == SER_RDATA && sclk_fall) begin
                o_sdo <= rdata_q[4];
                o_sdo_oe <= 1'b1;
            end
        end
    end

    // Register file, written only once the last data bit has arrived.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            regs_q[ADDR_MODE] <= RST_MODE;
            regs_q[ADDR_PLL2] <= RST_PLL2;
            regs_q[ADDR_OUT1] <= RST_OUT1;
            regs_q[ADDR_OUT2] <= RST_OUT2;
            regs_q[ADDR_OEN] <= RST_OEN;
        end else if (wr_q && head_q[2:0] < 3'(REG_COUNT)) begin
            regs_q[head_q[2:0]] <= wdata_q;
        end
    end

    assign mode_reg = regs_q[ADDR_MODE];
    assign pll2_reg = regs_q[ADDR_PLL2];
    assign out1_reg = regs_q[ADDR_OUT1];
    assign out2_reg = regs_q[ADDR_OUT2];
    assign oen_reg = regs_q[ADDR_OEN];

    // Mode decoding; the high-speed reverse decode does not look at the strap.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_hs_reverse <= 1'b0;
            o_fwd_slave <= 1'b0;
            o_slave <= 1'b0;
            o_mode_code <= 4'h0;
            o_ref_64k <= 1'b0;
            o_ref_8k <= 1'b0;
        end else begin
            o_mode_code <= mode_reg[4:1];
            o_hs_reverse <= mode_reg[4:1] == MODE_HS_REVERSE;
            o_ref_64k <= mode_reg[4:1] == MODE_HS_REVERSE;
            o_slave <= !strap_s2_q;
            o_fwd_slave <= !strap_s2_q && mode_reg[4:1] != MODE_HS_REVERSE;
            o_ref_8k <= !strap_s2_q && mode_reg[4:1] != MODE_HS_REVERSE;
        end
    end

    // Multiplier decoding for both outputs.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_out1_hs_mult <= MULT_X1;
            o_out2_hs_mult <= MULT_X1;
            o_out1_multiple <= 6'h01;
            o_out2_multiple <= 6'h01;
        end else begin
            o_out1_hs_mult <= hs_mult(out1_reg);
            o_out2_hs_mult <= hs_mult(out2_reg);
            o_out1_multiple <= {1'b0, out1_reg} + 6'h01;
            o_out2_multiple <= {1'b0, out2_reg} + 6'h01;
        end
    end

    // PLL runs, driver enables and lock-detect controls.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_first_clock_run <= 1'b0;
            o_second_clock_run <= 1'b0;
            o_first_clock_drive <= 1'b0;
            o_second_clock_drive <= 1'b0;
            o_frame_pulse_enable <= 1'b0;
            o_pll1_lock_detect_enable <= 1'b0;
            o_pll2_lock_detect_enable <= 1'b0;
        end else begin
            o_first_clock_run <= mode_reg[BIT_PLL_EN];
            o_second_clock_run <= pll2_reg[BIT_PLL_EN];
            o_first_clock_drive <= mode_reg[BIT_PLL_EN] && oen_reg[BIT_DRV1_EN];
            o_second_clock_drive <= pll2_reg[BIT_PLL_EN] && oen_reg[BIT_DRV2_EN];
            o_frame_pulse_enable <= oen_reg[BIT_FRAME_EN];
            o_pll1_lock_detect_enable <= !oen_reg[BIT_LDET1_DIS];
            o_pll2_lock_detect_enable <= !oen_reg[BIT_LDET2_DIS];
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    hs_strap_free_a: assert property ($changed(strap_s2_q) && $stable(mode_reg) && $stable(out1_reg)
        |=> $stable(o_hs_reverse) && $stable(o_out1_hs_mult))
        else $error("High-speed decode moved with the strap.");
    hs_code_a: assert property (mode_reg[4:1] == 4'hD |=> o_hs_reverse && o_ref_64k && !o_fwd_slave)
        else $error("Mode code 1101 not decoded as high-speed reverse.");
    out1_mult_a: assert property ($past(out1_reg[4:1]) == 4'h1 |-> o_out1_hs_mult == 4'h2)
        else $error("First output code 0001X did not give M of 2.");
    out2_mult_a: assert property (out2_reg[4:2] == 3'h1 |=> o_out2_hs_mult == 4'h4)
        else $error("Second output code 001XX did not give M of 4.");
    first_run_a: assert property (!mode_reg[0] [*2] |-> !o_first_clock_run && !o_first_clock_drive)
        else $error("First clock enabled with its PLL bit clear.");
    second_run_a: assert property (!pll2_reg[0] ##1 1'b1 |-> !o_second_clock_run && !o_second_clock_drive)
        else $error("Second clock enabled with its PLL bit clear.");
    frame_en_a: assert property (oen_reg[4] && !oen_reg[0] |=> o_frame_pulse_enable && o_pll1_lock_detect_enable)
        else $error("Output enable register bits misdecoded.");
    multiple_a: assert property (out1_reg == 5'h00 |=> o_out1_multiple == 6'h01)
        else $error("Zero in first select did not give a multiple of one.");
    multiple2_a: assert property (out2_reg == 5'h1F |=> o_out2_multiple == 6'h20)
        else $error("Second select 11111 did not give a multiple of 32.");
    fwd_slave_a: assert property (!strap_s2_q && mode_reg[4:1] != 4'hD |=> o_fwd_slave && o_ref_8k)
        else $error("Forward/slave mode not reported.");
    commit_a: assert property (ser_q != SER_WDATA && !wr_q |=> $stable(mode_reg) && $stable(out1_reg))
        else $error("Register changed outside a completed write.");
    out1_mult8_a: assert property (out1_reg[4] || out1_reg[3] |=> o_out1_hs_mult == 4'h8)
        else $error("First output code with bit 3 or 4 set did not give M of 8.");
    out2_mult1_a: assert property (out2_reg[4:1] == 4'h0 |=> o_out2_hs_mult == 4'h1)
        else $error("Second output code 0000X did not give M of 1.");
    drive2_a: assert property (pll2_reg[0] && oen_reg[2] |=> o_second_clock_drive)
        else $error("Second clock driver not enabled.");
    partial_a: assert property (ser_q == SER_WDATA && !cs_active |=> !wr_q)
        else $error("Cut write frame committed a register.");

endmodule
`default_nettype wire

// File: dv/pmc_host.sv
// Host model that drives the serial control port of the register bank.
`default_nettype none
module pmc_host (
    // Clock.
    input wire logic i_clk,
    // Serial port towards the device.
    input wire logic i_sdo,
    output logic o_sclk,
    output logic o_sdi,
    output logic o_cs_n
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_sclk = 1'b0;
        o_sdi = 1'b1;
        o_cs_n = 1'b1;
    end

    // Each serial clock phase lasts six system clocks, twice the minimum.
    task automatic half();
        repeat (6) @(posedge i_clk);
    endtask

    task automatic put(input logic b);
        o_sdi <= b;
        half();
        o_sclk <= 1'b1;
        half();
        o_sclk <= 1'b0;
    endtask

    // A frame sends the read flag, the address, then n data bits or reads five bits.
    task automatic xfer(input logic rd, input logic [2:0] a, input logic [4:0] d, input int n,
                        output logic [4:0] q);
        logic [8:0] bits;
        int i;
        bits = {rd, a, d};
        q = 5'h00;
        o_cs_n <= 1'b0;
        half();
        for (i = 0; i < 4 + (rd ? 0 : n); i++) begin
            put(bits[8-i]);
        end
        if (rd) begin
            for (i = 0; i < 5; i++) begin
                half();
                q[4-i] = i_sdo;
                o_sclk <= 1'b1;
                half();
                o_sclk <= 1'b0;
            end
        end
        half();
        o_cs_n <= 1'b1;
        o_sdi <= ~o_sdi;
        half();
    endtask
endmodule
`default_nettype wire

// File: dv/pmc_regs_test.sv
// Testbench for the command register bank and its mode decoding.
`default_nettype none
module pmc_regs_test
    import pmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst, prim_sel, sclk, sdi, cs_n, sdo, sdo_oe, hs, fs, slave, ref64, ref8;
    logic run1, run2, drv1, drv2, frame_en, ld1, ld2;
    logic [3:0] mcode, m1, m2;
    logic [5:0] l1, l2;
    logic [4:0] q;
    int failures = 0;
    int check_count = 0;
    int k;
    logic oe_seen = 1'b0;
    logic [4:0] vals [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h07, 5'h08, 5'h10, 5'h1F};
    logic [3:0] mexp [9] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h4, 4'h8, 4'h8, 4'h8};

    always #12.5 clk = ~clk;

    // Notes whether the device drove its serial output during a read.
    always @(posedge clk) begin
        if (sdo_oe) begin
            oe_seen <= 1'b1;
        end
    end

    pmc_host i_pmc_host (.i_clk(clk), .i_sdo(sdo), .o_sclk(sclk), .o_sdi(sdi), .o_cs_n(cs_n));

    pmc_regs i_pmc_regs (
        .i_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_sdi(sdi), .i_cs_n(cs_n), .o_sdo(sdo),
        .o_sdo_oe(sdo_oe), .i_primary_sel(prim_sel), .o_hs_reverse(hs), .o_fwd_slave(fs),
        .o_slave(slave), .o_mode_code(mcode), .o_ref_64k(ref64), .o_ref_8k(ref8),
        .o_out1_hs_mult(m1), .o_out2_hs_mult(m2), .o_out1_multiple(l1), .o_out2_multiple(l2),
        .o_first_clock_run(run1), .o_second_clock_run(run2), .o_first_clock_drive(drv1),
        .o_second_clock_drive(drv2), .o_frame_pulse_enable(frame_en),
        .o_pll1_lock_detect_enable(ld1), .o_pll2_lock_detect_enable(ld2)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [4:0] d);
        i_pmc_host.xfer(1'b0, a, d, 5, q);
        repeat (2) @(posedge clk);
    endtask

    task automatic rdchk(input logic [2:0] a, input logic [4:0] exp);
        oe_seen = 1'b0;
        i_pmc_host.xfer(1'b1, a, 5'h00, 0, q);
        chk({3'h0, q}, {3'h0, exp});
        chk({6'h0, oe_seen, sdo_oe}, 8'h02);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        $display("watchdog expired at %0t", $time);
        stop_test();
    end

    initial begin
        rst = 1'b1;
        prim_sel = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        for (k = 0; k < 5; k++) begin
            rdchk(3'(k), 5'h00);
        end
        chk({ld1, ld2, m1, 2'h0}, 8'hC4);
        $display("test reset done");
        wr(ADDR_MODE, 5'h1B);
        chk({4'h0, hs, ref64, fs, run1}, 8'h0D);
        chk({4'h0, mcode}, 8'h0D);
        wr(ADDR_PLL2, 5'h01);
        chk({7'h0, run2}, 8'h01);
        prim_sel <= 1'b1;
        repeat (4) @(posedge clk);
        chk({4'h0, hs, ref64, slave, fs}, 8'h0C);
        $display("test reverse mode done");
        for (k = 0; k < 9; k++) begin
            wr(ADDR_OUT1, vals[k]);
            wr(ADDR_OUT2, vals[8-k]);
            chk({4'h0, m1}, {4'h0, mexp[k]});
            chk({4'h0, m2}, {4'h0, mexp[8-k]});
        end
        $display("test multiplier table done");
        prim_sel <= 1'b0;
        wr(ADDR_MODE, 5'h02);
        chk({3'h0, hs, fs, ref8, run1, drv1}, 8'h0C);
        wr(ADDR_OUT1, 5'h00);
        chk({2'h0, l1}, 8'h01);
        wr(ADDR_OUT1, 5'h1F);
        chk({2'h0, l1}, 8'h20);
        wr(ADDR_OUT2, 5'h0A);
        chk({2'h0, l2}, 8'h0B);
        $display("test forward mode done");
        wr(ADDR_OEN, 5'h1C);
        wr(ADDR_MODE, 5'h03);
        chk({3'h0, drv1, drv2, frame_en, ld2, ld1}, 8'h1F);
        wr(ADDR_OEN, 5'h0E);
        chk({3'h0, drv1, drv2, frame_en, ld2, ld1}, 8'h19);
        wr(ADDR_PLL2, 5'h00);
        chk({6'h0, drv2, run2}, 8'h00);
        rdchk(ADDR_OEN, 5'h0E);
        $display("test output enables done");
        i_pmc_host.xfer(1'b0, ADDR_MODE, 5'h1A, 4, q);
        repeat (4) @(posedge clk);
        chk({3'h0, hs, mcode}, 8'h01);
        rdchk(ADDR_MODE, 5'h03);
        wr(3'h5, 5'h1F);
        rdchk(3'h5, 5'h00);
        rdchk(ADDR_OUT2, 5'h0A);
        $display("test partial and unmapped done");
        stop_test();
    end
endmodule
`default_nettype wire
